// *** gauge_cal_pkg.sv ***
// Constants for the gauge calibration control block.
// Assumes a 50 MHz clk_i; nonvolatile storage and converters sit outside.
//
// What this block does
// - Average current inside the zero-current window is reported as zero.
// - The zero-current window defaults to 3 mA unless the stored setting overrides it.
// - Auto offset calibration starts once both I2C lines are low over 5 s at idle current.
// - Automatic calibration runs about 16 s, then its result replaces the counter offset trim.
// - Any counter offset calibration shorts the positive and negative sense inputs together.
// - The first time both I2C lines stay low over 20 s, the more accurate calibration is done.
// - A commanded short calibration in calibration mode gives a temporary trim, later superseded.
// - Current scales by the current gain factor; charge by the time-based charge gain factor.
// - A per-board external offset trim is subtracted as well as the counter offset trim.
// - Internal-sensor temperature gets an offset-only trim.
// - Thermistor temperature gets its own offset-only trim.
// - Cell voltage results get a stored offset trim.
// - After learning reaches 02, default and alternate profiles copy the first learned profile.
// - Default profiles stay in nonvolatile storage unless the mirror pass or a manual update rewrites them.
// - Profile enable flag: 0x55 active, 0x00 updated inactive, 0xff inactive defaults; the block outputs only 0xff and 0x55.
package gauge_cal_pkg;

  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned IDLE_SHORT_S    = 5;
  localparam int unsigned IDLE_LONG_S     = 20;
  localparam int unsigned AUTO_CAL_S      = 16;
  localparam int unsigned CMD_CAL_MS      = 250;
  localparam int unsigned SEC_CYCLES      = CLK_HZ;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;

  localparam int          DATA_W          = 16;
  localparam int          GAIN_FRAC       = 12;
  localparam int          PROF_W          = 8;
  localparam int          PROF_N          = 16;
  localparam int          PROF_IDX_W      = 4;
  localparam int          TIME_W          = 5;

  localparam logic [DATA_W-1:0] DEADBAND_DEF_MA = 16'h0003;
  localparam logic [7:0]  LEARN_DONE      = 8'h02;
  localparam logic [7:0]  FLAG_ACTIVE     = 8'h55;
  localparam logic [7:0]  FLAG_UPDATED    = 8'h00;
  localparam logic [7:0]  FLAG_DEFAULT    = 8'hff;

  typedef enum logic [1:0] {
    PROF_DEF_A,
    PROF_DEF_B,
    PROF_ALT_A,
    PROF_ALT_B
  } copy_target_t;

endpackage

// *** profile_mem.sv ***
// Small register memory holding one resistance profile.
// Assumes a single writer per cycle on the same clock.
`timescale 1ns/1ps
module profile_mem
  import gauge_cal_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  we_i,
  input  wire logic [PROF_IDX_W-1:0] waddr_i,
  input  wire logic [PROF_W-1:0]     wdata_i,
  input  wire logic [PROF_IDX_W-1:0] raddr_i,
  output logic      [PROF_W-1:0]     rdata_o
);
  logic [PROF_W-1:0] mem_q [PROF_N];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule

// *** sec_tick.sv ***
// One-pulse-per-period divider giving second or millisecond ticks.
// Assumes clr_i restarts the phase so timers count whole periods.
`timescale 1ns/1ps
module sec_tick #(
  parameter int unsigned PERIOD = 50_000_000
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clr_i,
  output logic      tick_o
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || clr_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q == 32'(PERIOD - 1)) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule

// *** gauge_calibration_control.sv ***
// Calibration scheduling, trim application and profile mirroring for a fuel gauge.
// Assumes I2C pins are asynchronous; measurement inputs and trims come from same-clock logic.
`timescale 1ns/1ps
module gauge_calibration_control
  import gauge_cal_pkg::*;
#(
  parameter int unsigned SEC_PERIOD = SEC_CYCLES,
  parameter int unsigned MS_PERIOD  = MS_CYCLES
) (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  // I2C pins, sampled only
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  // Mode and settings
  input  wire logic                     normal_mode_i,
  input  wire logic                     cal_mode_i,
  input  wire logic                     cal_cmd_i,
  input  wire logic                     deadband_set_i,
  input  wire logic        [DATA_W-1:0] deadband_nv_i,
  input  wire logic        [DATA_W-1:0] idle_current_limit_i,
  input  wire logic                     ext_therm_i,
  // Trims
  input  wire logic signed [DATA_W-1:0] current_gain_factor_i,
  input  wire logic signed [DATA_W-1:0] charge_gain_factor_i,
  input  wire logic signed [DATA_W-1:0] counter_offset_trim_nv_i,
  input  wire logic signed [DATA_W-1:0] board_offset_trim_i,
  input  wire logic signed [DATA_W-1:0] int_temp_offset_i,
  input  wire logic signed [DATA_W-1:0] ext_temp_offset_i,
  input  wire logic signed [DATA_W-1:0] cell_v_offset_i,
  // Raw results
  input  wire logic                     raw_valid_i,
  input  wire logic signed [DATA_W-1:0] raw_current_i,
  input  wire logic signed [DATA_W-1:0] raw_charge_i,
  input  wire logic signed [DATA_W-1:0] raw_int_temp_i,
  input  wire logic signed [DATA_W-1:0] raw_ext_temp_i,
  input  wire logic signed [DATA_W-1:0] raw_cell_v_i,
  input  wire logic signed [DATA_W-1:0] offset_sample_i,
  // Profile learning
  input  wire logic        [7:0]        learn_status_i,
  input  wire logic                     nv_update_i,
  input  wire logic                     prof_we_i,
  input  wire logic    [PROF_IDX_W-1:0] prof_addr_i,
  input  wire logic        [PROF_W-1:0] prof_wdata_i,
  input  wire logic    [PROF_IDX_W-1:0] def_raddr_i,
  // Outputs
  output logic                          sense_short_o,
  output logic                          cal_busy_o,
  output logic                          cal_accurate_o,
  output logic                          trim_temporary_o,
  output logic signed [DATA_W-1:0]      counter_offset_trim_o,
  output logic signed [DATA_W-1:0]      avg_current_o,
  output logic signed [DATA_W-1:0]      charge_o,
  output logic signed [DATA_W-1:0]      temperature_o,
  output logic signed [DATA_W-1:0]      cell_v_o,
  output logic                          result_valid_o,
  output logic        [PROF_W-1:0]      default_profile_a_o,
  output logic        [7:0]             profile_enable_flag_o,
  output logic                          mirror_done_o
);

  // ****************************************************************
  // I2C idle detection
  // ****************************************************************
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       bus_busy;
  logic       sec_tick;
  logic       ms_tick;
  logic [TIME_W-1:0] idle_sec_q;
  logic       long_cal_done_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_sync_q <= '0;
      sda_sync_q <= '0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
    end
  end

  assign bus_busy = scl_sync_q[1] | sda_sync_q[1];

  sec_tick #(.PERIOD(SEC_PERIOD)) u_sec (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .clr_i     (bus_busy),
    .tick_o    (sec_tick)
  );

  sec_tick #(.PERIOD(MS_PERIOD)) u_ms (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .clr_i     (1'b0),
    .tick_o    (ms_tick)
  );

  // Saturates so a very long idle never wraps back to zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || bus_busy) begin
      idle_sec_q <= '0;
    end else if (sec_tick && idle_sec_q != '1) begin
      idle_sec_q <= idle_sec_q + TIME_W'(1);
    end
  end

  // ****************************************************************
  // Counter offset calibration sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_AUTO,
    CAL_LONG,
    CAL_CMD
  } cal_state_t;

  cal_state_t cal_q;
  logic [TIME_W-1:0] cal_sec_q;
  logic [15:0] cmd_ms_q;
  logic signed [DATA_W+7:0] acc_q;
  logic [23:0] acc_n_q;
  logic abs_idle;
  logic signed [DATA_W-1:0] avg_abs;
  logic cal_finish;

  assign avg_abs  = avg_current_o[DATA_W-1] ? -avg_current_o : avg_current_o;
  assign abs_idle = avg_abs < $signed(idle_current_limit_i);

  // Sum of samples divided by a fixed count of 256, done as a shift by 8
  logic signed [DATA_W-1:0] cal_result;
  assign cal_result = acc_n_q == '0 ? '0 : DATA_W'(acc_q >>> 8);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cal_q     <= CAL_IDLE;
      cal_sec_q <= '0;
      cmd_ms_q  <= '0;
    end else begin
      unique case (cal_q)
        CAL_IDLE: begin
          cal_sec_q <= '0;
          cmd_ms_q  <= '0;
          if (cal_mode_i && cal_cmd_i) begin
            cal_q <= CAL_CMD;
          end else if (normal_mode_i && !long_cal_done_q &&
                       idle_sec_q > TIME_W'(IDLE_LONG_S)) begin
            cal_q <= CAL_LONG;
          end else if (normal_mode_i && abs_idle &&
                       idle_sec_q > TIME_W'(IDLE_SHORT_S)) begin
            cal_q <= CAL_AUTO;
          end
        end
        CAL_AUTO, CAL_LONG: begin
          if (bus_busy) begin
            cal_q <= CAL_IDLE;
          end else if (sec_tick) begin
            cal_sec_q <= cal_sec_q + TIME_W'(1);
            if (cal_sec_q == TIME_W'(AUTO_CAL_S - 1)) begin
              cal_q <= CAL_IDLE;
            end
          end
        end
        CAL_CMD: begin
          if (ms_tick) begin
            cmd_ms_q <= cmd_ms_q + 16'h0001;
            if (cmd_ms_q == 16'(CMD_CAL_MS - 1)) begin
              cal_q <= CAL_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign cal_finish = (cal_q == CAL_CMD && ms_tick && cmd_ms_q == 16'(CMD_CAL_MS - 1)) ||
                      ((cal_q == CAL_AUTO || cal_q == CAL_LONG) && !bus_busy && sec_tick &&
                       cal_sec_q == TIME_W'(AUTO_CAL_S - 1));

  // Accumulates offset samples taken with the sense inputs shorted
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || cal_q == CAL_IDLE) begin
      acc_q   <= '0;
      acc_n_q <= '0;
    end else if (raw_valid_i) begin
      acc_q   <= acc_q + (DATA_W+8)'(offset_sample_i);
      acc_n_q <= acc_n_q + 24'h00_0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      counter_offset_trim_o <= '0;
      trim_temporary_o      <= 1'b0;
      long_cal_done_q       <= 1'b0;
      cal_accurate_o        <= 1'b0;
    end else if (cal_finish) begin
      counter_offset_trim_o <= cal_result;
      trim_temporary_o      <= (cal_q == CAL_CMD);
      cal_accurate_o        <= (cal_q == CAL_LONG);
      if (cal_q == CAL_LONG) begin
        long_cal_done_q <= 1'b1;
      end
    end else if (nv_update_i) begin
      counter_offset_trim_o <= counter_offset_trim_nv_i;
      trim_temporary_o      <= 1'b0;
    end
  end

  assign cal_busy_o    = (cal_q != CAL_IDLE);
  assign sense_short_o = (cal_q != CAL_IDLE);

  // ****************************************************************
  // Measurement trims
  // ****************************************************************
  logic signed [DATA_W-1:0] cur_off;
  logic signed [2*DATA_W-1:0] cur_prod;
  logic signed [2*DATA_W-1:0] chg_prod;
  logic signed [DATA_W-1:0] cur_scaled;
  logic [DATA_W-1:0] deadband;

  assign cur_off    = raw_current_i - counter_offset_trim_o - board_offset_trim_i;
  assign cur_prod   = (2*DATA_W)'(cur_off) * (2*DATA_W)'(current_gain_factor_i);
  assign chg_prod   = (2*DATA_W)'(raw_charge_i - counter_offset_trim_o - board_offset_trim_i)
                      * (2*DATA_W)'(charge_gain_factor_i);
  assign cur_scaled = DATA_W'(cur_prod >>> GAIN_FRAC);
  assign deadband   = deadband_set_i ? deadband_nv_i : DEADBAND_DEF_MA;

  // Measurements freeze while the inputs are shorted for calibration
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      avg_current_o  <= '0;
      charge_o       <= '0;
      temperature_o  <= '0;
      cell_v_o       <= '0;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= raw_valid_i && !sense_short_o;
      if (raw_valid_i && !sense_short_o) begin
        if (cur_scaled > -$signed(deadband) && cur_scaled < $signed(deadband)) begin
          avg_current_o <= '0;
        end else begin
          avg_current_o <= cur_scaled;
        end
        charge_o      <= DATA_W'(chg_prod >>> GAIN_FRAC);
        temperature_o <= ext_therm_i ? raw_ext_temp_i - ext_temp_offset_i
                                     : raw_int_temp_i - int_temp_offset_i;
        cell_v_o      <= raw_cell_v_i - cell_v_offset_i;
      end
    end
  end

  // ****************************************************************
  // Resistance profiles
  // ****************************************************************
  typedef enum logic [1:0] {
    MIR_WAIT,
    MIR_COPY,
    MIR_DONE
  } mir_state_t;

  mir_state_t mir_q;
  logic [PROF_IDX_W-1:0] mir_idx_q;
  logic [PROF_IDX_W-1:0] mir_wr_idx_q;
  logic mir_wr_q;
  logic [PROF_W-1:0] learned_rd;
  logic [PROF_IDX_W-1:0] src_raddr;
  logic [3:0] tgt_we;
  logic [PROF_IDX_W-1:0] tgt_addr;
  logic [PROF_W-1:0] tgt_data;

  assign src_raddr = (mir_q == MIR_COPY) ? mir_idx_q : def_raddr_i;

  profile_mem u_learned (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (prof_we_i),
    .waddr_i   (prof_addr_i),
    .wdata_i   (prof_wdata_i),
    .raddr_i   (src_raddr),
    .rdata_o   (learned_rd)
  );

  // Defaults change only on the mirror pass or a manual update
  assign tgt_we   = mir_wr_q ? 4'hf : (nv_update_i && prof_we_i ? 4'h3 : 4'h0);
  assign tgt_addr = mir_wr_q ? mir_wr_idx_q : prof_addr_i;
  assign tgt_data = mir_wr_q ? learned_rd : prof_wdata_i;

  logic [PROF_W-1:0] tgt_rd [4];

  for (genvar g = 0; g < 4; g++) begin : g_tgt
    profile_mem u_tgt (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .we_i      (tgt_we[g]),
      .waddr_i   (tgt_addr),
      .wdata_i   (tgt_data),
      .raddr_i   (def_raddr_i),
      .rdata_o   (tgt_rd[g])
    );
  end

  assign default_profile_a_o = tgt_rd[PROF_DEF_A];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mir_q        <= MIR_WAIT;
      mir_idx_q    <= '0;
      mir_wr_idx_q <= '0;
      mir_wr_q     <= 1'b0;
    end else begin
      mir_wr_q     <= (mir_q == MIR_COPY);
      mir_wr_idx_q <= mir_idx_q;
      unique case (mir_q)
        MIR_WAIT: begin
          if (learn_status_i == LEARN_DONE) begin
            mir_q <= MIR_COPY;
          end
        end
        MIR_COPY: begin
          mir_idx_q <= mir_idx_q + PROF_IDX_W'(1);
          if (mir_idx_q == '1) begin
            mir_q <= MIR_DONE;
          end
        end
        MIR_DONE: begin
          mir_q <= MIR_DONE;
        end
        default: begin
          mir_q <= MIR_WAIT;
        end
      endcase
    end
  end

  assign mirror_done_o = (mir_q == MIR_DONE) && !mir_wr_q;

  // Flag turns FLAG_ACTIVE on any profile write or once mirroring is done; FLAG_UPDATED is never used
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      profile_enable_flag_o <= FLAG_DEFAULT;
    end else if (mir_q == MIR_DONE || prof_we_i) begin
      profile_enable_flag_o <= FLAG_ACTIVE;
    end
  end

endmodule

// *** gauge_calibration_control_asserts.sv ***
// Port assertions for the gauge calibration control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module gauge_calibration_control_asserts
  import gauge_cal_pkg::*;
#(
  parameter int unsigned SEC_PERIOD = SEC_CYCLES,
  parameter int unsigned MS_PERIOD  = MS_CYCLES
) (
  input wire logic                     clk_i,
  input wire logic                     sys_rst_i,
  input wire logic                     cal_mode_i,
  input wire logic                     cal_cmd_i,
  input wire logic                     deadband_set_i,
  input wire logic                     ext_therm_i,
  input wire logic                     nv_update_i,
  input wire logic                     raw_valid_i,
  input wire logic signed [DATA_W-1:0] int_temp_offset_i,
  input wire logic signed [DATA_W-1:0] ext_temp_offset_i,
  input wire logic signed [DATA_W-1:0] cell_v_offset_i,
  input wire logic signed [DATA_W-1:0] raw_int_temp_i,
  input wire logic signed [DATA_W-1:0] raw_ext_temp_i,
  input wire logic signed [DATA_W-1:0] raw_cell_v_i,
  input wire logic                     sense_short_o,
  input wire logic                     cal_busy_o,
  input wire logic                     result_valid_o,
  input wire logic                     mirror_done_o,
  input wire logic signed [DATA_W-1:0] counter_offset_trim_o,
  input wire logic signed [DATA_W-1:0] avg_current_o,
  input wire logic signed [DATA_W-1:0] temperature_o,
  input wire logic signed [DATA_W-1:0] cell_v_o,
  input wire logic        [7:0]        profile_enable_flag_o
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_short_busy;
    result_valid_o |-> $past(raw_valid_i) && !$past(sense_short_o);
  endproperty
  a_short_busy: assert property (p_short_busy) else $error("result from shorted inputs");
  // A shorted input would give a bogus reading, so none may be published
  property p_refuse;
    raw_valid_i && sense_short_o |=> !result_valid_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("result during short");
  property p_db;
    raw_valid_i && !sense_short_o && !deadband_set_i |=>
      avg_current_o == 0 || avg_current_o >= 3 || avg_current_o <= -3;
  endproperty
  a_db: assert property (p_db) else $error("current inside window");
  property p_temp;
    raw_valid_i && !sense_short_o |=> temperature_o == ($past(ext_therm_i)
      ? $past(raw_ext_temp_i) - $past(ext_temp_offset_i)
      : $past(raw_int_temp_i) - $past(int_temp_offset_i));
  endproperty
  a_temp: assert property (p_temp) else $error("temperature trim wrong");
  property p_cell_v;
    raw_valid_i && !sense_short_o |=> cell_v_o + $past(cell_v_offset_i) == $past(raw_cell_v_i);
  endproperty
  a_cell_v: assert property (p_cell_v) else $error("cell voltage trim wrong");
  property p_trim_hold;
    !sense_short_o && !nv_update_i |=> $stable(counter_offset_trim_o);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim moved outside cal");
  property p_cmd;
    cal_mode_i && cal_cmd_i && !sense_short_o |=> sense_short_o [*8];
  endproperty
  a_cmd: assert property (p_cmd) else $error("commanded cal not held");
  property p_flag;
    mirror_done_o |-> profile_enable_flag_o == FLAG_ACTIVE;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not active");
  c_cal_end: cover property ($fell(sense_short_o));
  c_mirror: cover property ($rose(mirror_done_o));
  c_zero: cover property (result_valid_o && avg_current_o == 0);
endmodule

bind gauge_calibration_control gauge_calibration_control_asserts #(
  .SEC_PERIOD(SEC_PERIOD),
  .MS_PERIOD(MS_PERIOD)
) u_chk (.*);

// *** gauge_host_model.sv ***
// Host side of the I2C pins.
// Assumes the bench says whether the host is powered and talking.
`timescale 1ns/1ps
module gauge_host_model (
  input  wire logic clk_i,
  input  wire logic host_on_i,
  output logic      scl_o,
  output logic      sda_o
);
  // A live host clocks with data pulled up; a host that is off sinks both
  initial {scl_o, sda_o} = 2'h3;
  always @(posedge clk_i) begin
    #1;
    scl_o = host_on_i & ~scl_o;
    sda_o = host_on_i;
  end
endmodule

// *** gauge_calibration_control_tb.sv ***
// Self-checking bench for the gauge calibration control block.
// Assumes the host model owns the I2C pins; shortened tick periods.
`timescale 1ns/1ps
module gauge_calibration_control_tb;
  import gauge_cal_pkg::*;
  logic clk_i, sys_rst_i, scl_i, sda_i, host_on, normal_mode_i, cal_mode_i, cal_cmd_i;
  logic deadband_set_i, ext_therm_i, raw_valid_i, nv_update_i, prof_we_i, mirror_done_o;
  logic sense_short_o, cal_busy_o, cal_accurate_o, trim_temporary_o, result_valid_o;
  logic [DATA_W-1:0] deadband_nv_i, idle_current_limit_i;
  logic signed [DATA_W-1:0] current_gain_factor_i, charge_gain_factor_i, board_offset_trim_i;
  logic signed [DATA_W-1:0] counter_offset_trim_nv_i, int_temp_offset_i, ext_temp_offset_i;
  logic signed [DATA_W-1:0] cell_v_offset_i, raw_current_i, raw_charge_i, raw_int_temp_i;
  logic signed [DATA_W-1:0] raw_ext_temp_i, raw_cell_v_i, offset_sample_i, cell_v_o;
  logic signed [DATA_W-1:0] counter_offset_trim_o, avg_current_o, charge_o, temperature_o;
  logic [7:0] learn_status_i, profile_enable_flag_o;
  logic [PROF_IDX_W-1:0] prof_addr_i, def_raddr_i;
  logic [PROF_W-1:0] prof_wdata_i, default_profile_a_o;
  logic [PROF_W-1:0] prof [PROF_N];
  int cv [8] = '{3, 2, -3, -2, 0, 1, -1, 4};
  int seed = 15855;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int exp_trim = 0;

  gauge_calibration_control #(.SEC_PERIOD(10), .MS_PERIOD(2)) dut (.*);
  gauge_host_model host (.clk_i(clk_i), .host_on_i(host_on), .scl_o(scl_i), .sda_o(sda_i));

  // ********
  // Helpers
  // ********
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(string n, logic [DATA_W-1:0] s, logic [DATA_W-1:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask

  function automatic logic [DATA_W-1:0] f_cur(int raw, int g, int db);
    int v;
    v = ((raw - exp_trim - board_offset_trim_i) * g) >>> 12;
    if (v > -db && v < db) v = 0;
    return v[DATA_W-1:0];
  endfunction

  task automatic meas;
    int db;
    db = deadband_set_i ? deadband_nv_i : 3;
    raw_valid_i = 1;
    tick;
    raw_valid_i = 0;
    chk("valid", 16'(result_valid_o), 16'h0001);
    chk("avg", avg_current_o, f_cur(raw_current_i, current_gain_factor_i, db));
    chk("charge", charge_o, f_cur(raw_charge_i, charge_gain_factor_i, 0));
    chk("temp", temperature_o, ext_therm_i ? raw_ext_temp_i - ext_temp_offset_i
        : raw_int_temp_i - int_temp_offset_i);
    chk("cell", cell_v_o, raw_cell_v_i - cell_v_offset_i);
    tick;
  endtask

  // Samples fed while shorted; they make up the offset sum
  task automatic samp(int n, logic [DATA_W-1:0] v);
    offset_sample_i = v;
    repeat (n) begin
      raw_valid_i = 1;
      tick;
      chk("short", 16'(sense_short_o), 16'h0001);
      chk("busy", 16'(cal_busy_o), 16'h0001);
      chk("refused", 16'(result_valid_o), 16'h0000);
    end
    raw_valid_i = 0;
  endtask

  task automatic wait_lvl(bit sel, logic lvl, int lim);
    int k = 0;
    while ((sel ? mirror_done_o : sense_short_o) !== lvl && k < lim) begin
      tick;
      k++;
    end
    chk("wait", 16'(sel ? mirror_done_o : sense_short_o), 16'(lvl));
  endtask

  // Mode 0 reads default a, 1 writes and remembers, 2 writes only
  task automatic prof_io(int mode);
    for (int a = 0; a < PROF_N; a++) begin
      if (mode != 0) prof_we_i = 1;
      prof_addr_i = PROF_IDX_W'(a);
      def_raddr_i = PROF_IDX_W'(a);
      prof_wdata_i = 8'($random(seed));
      if (mode == 1) prof[a] = prof_wdata_i;
      tick;
      if (mode == 0) chk("def", default_profile_a_o, prof[a]);
    end
    prof_we_i = 0;
    tick;
  endtask

  task automatic report_and_stop;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    {clk_i, normal_mode_i, cal_mode_i, cal_cmd_i, deadband_set_i, ext_therm_i} = '0;
    {raw_valid_i, nv_update_i, prof_we_i, prof_addr_i, def_raddr_i, prof_wdata_i} = '0;
    {current_gain_factor_i, charge_gain_factor_i, board_offset_trim_i, int_temp_offset_i} = '0;
    {ext_temp_offset_i, cell_v_offset_i, raw_current_i, raw_charge_i, raw_int_temp_i} = '0;
    {raw_ext_temp_i, raw_cell_v_i, offset_sample_i, learn_status_i} = '0;
    {sys_rst_i, host_on} = 2'h3;
    deadband_nv_i = 16'h0005;
    idle_current_limit_i = 16'h0064;
    counter_offset_trim_nv_i = 16'h0005;
    repeat (2) @(posedge clk_i);
    #1 sys_rst_i = 0;
    chk("flag", profile_enable_flag_o, FLAG_DEFAULT);
    nv_update_i = 1;
    tick;
    nv_update_i = 0;
    exp_trim = 5;
    chk("nvtrim", counter_offset_trim_o, 16'h0005);
    prof_io(1);
    chk("flag", profile_enable_flag_o, FLAG_ACTIVE);
    learn_status_i = LEARN_DONE;
    wait_lvl(1, 1'b1, 40);
    learn_status_i = 8'h00;
    prof_io(0);
    prof_io(2);
    prof_io(0);
    // Manual update is the one path that may rewrite the defaults
    nv_update_i = 1;
    prof_io(1);
    nv_update_i = 0;
    prof_io(0);
    for (int i = 0; i < 40; i++) begin
      current_gain_factor_i = 16'(2048 + {$random(seed)} % 4096);
      charge_gain_factor_i = 16'(2048 + {$random(seed)} % 4096);
      board_offset_trim_i = 16'($random(seed) % 50);
      raw_current_i = 16'($random(seed) % 1000);
      raw_charge_i = 16'($random(seed) % 1000);
      {raw_int_temp_i, raw_ext_temp_i} = $random(seed);
      {raw_cell_v_i, cell_v_offset_i} = $random(seed);
      {int_temp_offset_i, ext_temp_offset_i} = $random(seed);
      {deadband_set_i, ext_therm_i} = 2'($random(seed));
      deadband_nv_i = 16'({$random(seed)} % 16);
      if (i < 8) begin
        current_gain_factor_i = 16'h1000;
        deadband_set_i = 0;
        raw_current_i = 16'(exp_trim + board_offset_trim_i + cv[i]);
      end
      meas;
    end
    cal_mode_i = 1;
    cal_cmd_i = 1;
    tick;
    cal_cmd_i = 0;
    samp(4, 16'h0100);
    repeat (400) tick;
    chk("cmdrun", 16'(sense_short_o), 16'h0001);
    wait_lvl(0, 1'b0, 150);
    chk("cmdtrim", counter_offset_trim_o, 16'h0004);
    chk("tmp", 16'(trim_temporary_o), 16'h0001);
    cal_mode_i = 0;
    exp_trim = 4;
    normal_mode_i = 1;
    raw_current_i = 16'(exp_trim + board_offset_trim_i);
    meas;
    host_on = 0;
    repeat (55) tick;
    chk("early", 16'(sense_short_o), 16'h0000);
    wait_lvl(0, 1'b1, 20);
    host_on = 1;
    repeat (6) tick;
    chk("abort", 16'(sense_short_o), 16'h0000);
    chk("keep", counter_offset_trim_o, 16'h0004);
    host_on = 0;
    repeat (55) tick;
    chk("restart", 16'(sense_short_o), 16'h0000);
    wait_lvl(0, 1'b1, 20);
    samp(8, 16'h0100);
    repeat (140) tick;
    chk("autorun", 16'(sense_short_o), 16'h0001);
    wait_lvl(0, 1'b0, 40);
    chk("autotrim", counter_offset_trim_o, 16'h0008);
    chk("acc0", 16'(cal_accurate_o), 16'h0000);
    wait_lvl(0, 1'b1, 40);
    samp(4, 16'h0300);
    wait_lvl(0, 1'b0, 200);
    chk("longtrim", counter_offset_trim_o, 16'h000c);
    chk("acc1", 16'(cal_accurate_o), 16'h0001);
    chk("tmp0", 16'(trim_temporary_o), 16'h0000);
    report_and_stop;
  end
endmodule
